// >>> cpu_ops_params.svh
`ifndef CPU_OPS_PARAMS_SVH
`define CPU_OPS_PARAMS_SVH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define INSTR_W 14
`define DATA_W 8
`define FADDR_W 7
`define PC_W 13

// ----------------------------------------------------------------
// opcode patterns (mask, then value after masking; return and config are exact words)
// ----------------------------------------------------------------
`define OP_STORE_MASK 14'h3F80
`define OP_STORE_VAL 14'h0080
`define OP_IDLE_MASK 14'h3F9F
`define OP_IDLE_VAL 14'h0000
`define OP_RETI 14'h0009
`define OP_CFG_LOAD 14'h0062

// ----------------------------------------------------------------
// fields, addresses, reset values, timing
// ----------------------------------------------------------------
`define IRQ_EN_BIT 7
`define CFG_FADDR 7'h01
`define CFG_RESET 8'hFF
`define RETI_CYCLES 2

`endif

// >>> cpu_ops_pkg.sv
`default_nettype none
`include "cpu_ops_params.svh"

package cpu_ops_pkg;

  // decoded instruction class
  typedef enum logic [2:0] {
    OP_OTHER = 3'b000,
    OP_IDLE  = 3'b001,
    OP_STORE = 3'b010,
    OP_RETI  = 3'b011,
    OP_CFG   = 3'b100
  } op_kind_t;

  // execution phase; second phase of a return is a dead cycle
  typedef enum logic {
    ST_RUN  = 1'b0,
    ST_RET2 = 1'b1
  } exec_state_t;

  // one file register write
  typedef struct packed {
    logic we;
    logic [`FADDR_W-1:0] addr;
    logic [`DATA_W-1:0] data;
  } file_wr_t;

endpackage

`default_nettype wire

// >>> cpu_move_return_ops.sv
`timescale 1ns/1ps
`default_nettype none
`include "cpu_ops_params.svh"

// Summary of operation
// - A return pops the stack and loads the stack top into the pc.
// - A return also sets the global irq enable, bit 7 of irq control.
// - A return takes two cycles; the second takes no new instruction, no flag moves.
// - The config opcode copies the accumulator to timer config at once.
// - The timer config register is also an ordinary file register.
// - The idle opcode takes one cycle, changes nothing, ignores x bits.
module cpu_move_return_ops
  import cpu_ops_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic instr_valid,
  output logic instr_ready,
  input wire logic [`INSTR_W-1:0] instr_word,
  input wire logic [`DATA_W-1:0] acc_value,
  input wire logic [`PC_W-1:0] stack_top,
  input wire file_wr_t core_file_wr,
  input wire logic [`FADDR_W-1:0] file_rd_addr,
  output logic [`DATA_W-1:0] file_rd_data,
  output logic file_rd_hit,
  output file_wr_t store_file_wr,
  output logic pc_load,
  output logic [`PC_W-1:0] pc_value,
  output logic stack_pop,
  output logic [`DATA_W-1:0] irq_ctrl_set_mask,
  output logic [`DATA_W-1:0] timer_cfg
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_meta_q;
  logic rst_sync_q;
  logic rst_core_n;

  // async assert, two-flop release so all flops leave reset together
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  assign rst_core_n = rst_sync_q;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  function automatic op_kind_t decode_op(input logic [`INSTR_W-1:0] w);
    op_kind_t k;
    k = OP_OTHER;
    if ((w & `OP_STORE_MASK) == `OP_STORE_VAL)
      k = OP_STORE;
    else if ((w & `OP_IDLE_MASK) == `OP_IDLE_VAL)
      k = OP_IDLE;
    else if (w == `OP_RETI)
      k = OP_RETI;
    else if (w == `OP_CFG_LOAD)
      k = OP_CFG;
    return k;
  endfunction

  // config register sits in the file map at a fixed address
  function automatic logic is_cfg_addr(input logic [`FADDR_W-1:0] a);
    return a == `CFG_FADDR;
  endfunction

  exec_state_t state_q;
  exec_state_t state_d;
  op_kind_t op_kind;
  logic taken;
  logic take_store;
  logic take_reti;
  logic take_cfg;
  logic store_hits_cfg;
  logic core_hits_cfg;

  // a request is taken only while not in the dead return cycle
  assign instr_ready = (state_q == ST_RUN);
  assign taken = instr_valid && instr_ready;
  assign op_kind = decode_op(instr_word);
  assign take_store = taken && (op_kind == OP_STORE);
  assign take_reti = taken && (op_kind == OP_RETI);
  assign take_cfg = taken && (op_kind == OP_CFG);
  assign store_hits_cfg = take_store && is_cfg_addr(instr_word[6:0]);
  assign core_hits_cfg = core_file_wr.we && is_cfg_addr(core_file_wr.addr);

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  // second return cycle stalls the fetch; nothing else moves
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      ST_RUN:
      begin
        if (take_reti)
          state_d = ST_RET2;
      end
      ST_RET2:
      begin
        state_d = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_core_n)
  begin
    if (!rst_core_n)
      state_q <= ST_RUN;
    else
      state_q <= state_d;
  end

  // ----------------------------------------------------------------
  // program counter, stack and interrupt enable
  // ----------------------------------------------------------------
  logic pc_load_q;
  logic pop_q;
  logic irq_en_set_q;
  logic [`PC_W-1:0] pc_q;

  // pulses land in the dead cycle, so the refetch sees the new pc
  always_ff @(posedge sys_clk or negedge rst_core_n)
  begin
    if (!rst_core_n)
    begin
      pc_load_q <= 1'b0;
      pop_q <= 1'b0;
      irq_en_set_q <= 1'b0;
      pc_q <= '0;
    end
    else
    begin
      pc_load_q <= take_reti;
      pop_q <= take_reti;
      irq_en_set_q <= take_reti;
      if (take_reti)
        pc_q <= stack_top;
    end
  end

  assign pc_load = pc_load_q;
  assign pc_value = pc_q;
  assign stack_pop = pop_q;
  // set-only mask; the interrupt controller ORs it in, never clears
  assign irq_ctrl_set_mask =
    irq_en_set_q ? (`DATA_W'(1) << `IRQ_EN_BIT) : '0;

  // ----------------------------------------------------------------
  // file store and configuration register
  // ----------------------------------------------------------------
  file_wr_t wr_q;
  logic [`DATA_W-1:0] cfg_q;
  logic [`DATA_W-1:0] rd_q;
  logic rd_hit_q;

  // store goes out to the file map one cycle after it is taken
  always_ff @(posedge sys_clk or negedge rst_core_n)
  begin
    if (!rst_core_n)
      wr_q <= '0;
    else
    begin
      wr_q.we <= take_store;
      wr_q.addr <= instr_word[6:0];
      wr_q.data <= acc_value;
    end
  end

  // opcode and own store win over a simultaneous core write
  always_ff @(posedge sys_clk or negedge rst_core_n)
  begin
    if (!rst_core_n)
      cfg_q <= `CFG_RESET;
    else if (take_cfg || store_hits_cfg)
      cfg_q <= acc_value;
    else if (core_hits_cfg)
      cfg_q <= core_file_wr.data;
  end

  // registered read port; other addresses belong to the rest of the map
  always_ff @(posedge sys_clk or negedge rst_core_n)
  begin
    if (!rst_core_n)
    begin
      rd_q <= '0;
      rd_hit_q <= 1'b0;
    end
    else
    begin
      rd_hit_q <= is_cfg_addr(file_rd_addr);
      rd_q <= is_cfg_addr(file_rd_addr) ? cfg_q : '0;
    end
  end

  assign store_file_wr = wr_q;
  assign timer_cfg = cfg_q;
  assign file_rd_data = rd_q;
  assign file_rd_hit = rd_hit_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_core_n);

  sequence s_reti_taken;
    instr_valid && instr_ready && instr_word == `OP_RETI;
  endsequence

  sequence s_dead_then_run;
    !instr_ready && !store_file_wr.we ##1 instr_ready;
  endsequence

  a_reti_pc_pop: assert property (
    s_reti_taken |=> pc_load && stack_pop && pc_value == $past(stack_top))
    else $error("return did not load pc from stack top");

  a_reti_irq_enable: assert property (
    s_reti_taken |=> irq_ctrl_set_mask == 8'h80
    ##1 irq_ctrl_set_mask == 8'h00)
    else $error("return did not pulse the enable bit");

  a_reti_two_cycles: assert property (
    s_reti_taken |=> s_dead_then_run)
    else $error("return did not take exactly two cycles");

  a_cfg_load_acc: assert property (
    instr_valid && instr_ready && instr_word == `OP_CFG_LOAD
    |=> timer_cfg == $past(acc_value) && instr_ready)
    else $error("config opcode did not load accumulator");

  a_cfg_file_rw: assert property (
    core_file_wr.we && core_file_wr.addr == 7'h01 && !taken
    |=> timer_cfg == $past(core_file_wr.data)
    ##1 (file_rd_hit == ($past(file_rd_addr) == 7'h01)))
    else $error("config register file access failed");

  a_idle_quiet: assert property (
    instr_valid && instr_ready && (instr_word & 14'h3F9F) == 14'h0000
    && !core_file_wr.we
    |=> !store_file_wr.we && !pc_load && $stable(timer_cfg) && instr_ready)
    else $error("idle instruction changed state");

  a_store_write: assert property (
    instr_valid && instr_ready && (instr_word & 14'h3F80) == 14'h0080
    |=> store_file_wr.we && store_file_wr.addr == $past(instr_word[6:0])
    && store_file_wr.data == $past(acc_value) && !pc_load && !stack_pop)
    else $error("store did not write accumulator to file");

endmodule

`default_nettype wire

// >>> cpu_move_return_ops_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "cpu_ops_params.svh"

module cpu_move_return_ops_tb_top import cpu_ops_pkg::*;;
  logic sys_clk;
  logic rst_n;
  logic instr_valid;
  logic instr_ready;
  logic [`INSTR_W-1:0] instr_word;
  logic [`DATA_W-1:0] acc_value;
  logic [`DATA_W-1:0] file_rd_data;
  logic [`DATA_W-1:0] irq_ctrl_set_mask;
  logic [`DATA_W-1:0] timer_cfg;
  logic [`PC_W-1:0] stack_top;
  logic [`PC_W-1:0] pc_value;
  logic [`FADDR_W-1:0] file_rd_addr;
  file_wr_t core_file_wr;
  file_wr_t store_file_wr;
  logic file_rd_hit;
  logic pc_load;
  logic stack_pop;
  int n_mismatch;
  int n_tests;

  cpu_move_return_ops uut (
    .sys_clk(sys_clk), .rst_n(rst_n), .instr_valid(instr_valid),
    .instr_ready(instr_ready), .instr_word(instr_word),
    .acc_value(acc_value), .stack_top(stack_top),
    .core_file_wr(core_file_wr), .file_rd_addr(file_rd_addr),
    .file_rd_data(file_rd_data), .file_rd_hit(file_rd_hit),
    .store_file_wr(store_file_wr), .pc_load(pc_load), .pc_value(pc_value),
    .stack_pop(stack_pop), .irq_ctrl_set_mask(irq_ctrl_set_mask),
    .timer_cfg(timer_cfg)
  );

  // ----------------------------------------------------------------
  // clock and shared tasks
  // ----------------------------------------------------------------
  // 100 MHz
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // values widened to 16 bits so one compare serves every output
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish;
    if (n_mismatch == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // valid stays up so callers can issue back to back
  task automatic issue(input logic [13:0] w, input logic [7:0] a);
    instr_valid = 1'b1;
    instr_word = w;
    acc_value = a;
    @(negedge sys_clk);
  endtask

  task automatic stop;
    instr_valid = 1'b0;
    instr_word = 14'h3FFF;
    acc_value = 8'h00;
    @(negedge sys_clk);
  endtask

  // all one-cycle pulses low, ready high
  task automatic chk_quiet;
    chk({instr_ready, store_file_wr.we, pc_load, stack_pop, 4'h0,
      irq_ctrl_set_mask}, 16'h8000);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  // idle variants and near-miss opcodes must leave everything alone
  task automatic t_idle;
    logic [13:0] w [6] = '{14'h0000, 14'h0020, 14'h0040, 14'h0060,
      14'h0008, 14'h0063};
    foreach (w[i])
    begin
      issue(w[i], 8'h3C);
      chk_quiet();
      chk({8'h00, timer_cfg}, 16'h00FF);
    end
    stop();
  endtask

  // back-to-back stores, second one lands on the config address
  task automatic t_store;
    issue(14'h00FF, 8'hA5);
    chk(store_file_wr, {1'b1, 7'h7F, 8'hA5});
    issue(14'h0081, 8'h77);
    chk(store_file_wr, {1'b1, 7'h01, 8'h77});
    chk({8'h00, timer_cfg}, 16'h0077);
    stop();
    chk({15'h0000, store_file_wr.we}, 16'h0000);
  endtask

  // opcode load beats a core write to the same register
  task automatic t_cfg;
    core_file_wr = {1'b1, 7'h01, 8'h33};
    issue(14'h0062, 8'h5A);
    core_file_wr = {1'b0, 7'h00, 8'h00};
    chk({8'h00, timer_cfg}, 16'h005A);
    chk_quiet();
    stop();
    core_file_wr = {1'b1, 7'h01, 8'hC3};
    file_rd_addr = 7'h01;
    @(negedge sys_clk);
    core_file_wr = {1'b0, 7'h00, 8'h00};
    chk({8'h00, timer_cfg}, 16'h00C3);
    @(negedge sys_clk);
    chk({7'h00, file_rd_hit, file_rd_data}, 16'h01C3);
    file_rd_addr = 7'h02;
    @(negedge sys_clk);
    chk({7'h00, file_rd_hit, file_rd_data}, 16'h0000);
  endtask

  // return, then a store held through the dead cycle
  task automatic t_return;
    stack_top = 13'h1ABC;
    issue(14'h0009, 8'h00);
    stack_top = 13'h0555;
    instr_word = 14'h0085;
    acc_value = 8'h11;
    chk({3'h0, pc_value}, 16'h1ABC);
    chk({instr_ready, pc_load, stack_pop, 13'h0000}, 16'h6000);
    chk({8'h00, irq_ctrl_set_mask}, 16'h0080);
    @(negedge sys_clk);
    chk({3'h0, pc_load, stack_pop, store_file_wr.we, 9'h000,
      irq_ctrl_set_mask[`IRQ_EN_BIT]}, 16'h0000);
    chk({15'h0000, instr_ready}, 16'h0001);
    @(negedge sys_clk);
    chk(store_file_wr, {1'b1, 7'h05, 8'h11});
    stop();
  endtask

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    n_mismatch = 0;
    n_tests = 0;
    rst_n = 1'b0;
    instr_valid = 1'b0;
    instr_word = 14'h3FFF;
    acc_value = 8'h00;
    stack_top = 13'h0000;
    core_file_wr = {1'b0, 7'h00, 8'h00};
    file_rd_addr = 7'h00;
    repeat (20) @(negedge sys_clk);
    chk({8'h00, timer_cfg}, 16'h00FF);
    rst_n = 1'b1;
    repeat (3) @(negedge sys_clk);
    t_idle();
    t_store();
    t_cfg();
    t_return();
    tally_and_finish();
  end

  // whole run is well under 100 cycles; 5000 leaves ample margin
  initial
  begin
    #50000;
    n_mismatch++;
    tally_and_finish();
  end
endmodule

`default_nettype wire
